// *** bench/asci_checker.sv ***
// Port-level assertions for the serial command interface
module asci_checker
	import asci_pkg::*;
(
	// System clock
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	// Link
	input wire logic        sclk,
	input wire logic        cs_n,
	input wire logic        serial_out_ready_pin,
	input wire logic        serial_out_oe_n,
	input wire logic        data_ready_n,
	// Converter side
	input wire logic        adc_valid,
	input wire logic        conv_run,
	input wire logic        conv_restart,
	input wire logic        sleep_mode,
	input wire logic [31:0] cfg_word
);
	timeunit 1ns;
	timeprecision 1ps;

	logic sclk_seen_q;
	logic cont_normal;

	// Once clocked, the combined pin carries shift data, not ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_seen_q <= 1'b0;
		end else if (cs_n) begin
			sclk_seen_q <= 1'b0;
		end else if (sclk) begin
			sclk_seen_q <= 1'b1;
		end
	end

	// Continuous conversions at the normal modulator rate
	assign cont_normal = cfg_word[CONV_POS] && (cfg_word[MODE_POS+1:MODE_POS] != MODE_TURBO);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	chk_oe_off_deselect: assert property (
		cs_n [*5] |-> serial_out_oe_n
	) else $error("combined pin driven while deselected");
	chk_oe_on_select: assert property (
		(!cs_n && ce) [*5] |-> !serial_out_oe_n
	) else $error("combined pin not driven while selected");
	chk_ready_new_data: assert property (
		adc_valid && conv_run && data_ready_n |=> !data_ready_n
	) else $error("ready did not fall on new result");
	chk_ready_gap_pulse: assert property (
		adc_valid && conv_run && !data_ready_n && cont_normal |-> ##2 data_ready_n [*8] ##[20:26] !data_ready_n
	) else $error("unread result gap pulse wrong");
	chk_pin_tracks_ready: assert property (
		$fell(data_ready_n) && cfg_word[RDYSEL_POS] && !serial_out_oe_n && !sclk_seen_q |-> !serial_out_ready_pin
	) else $error("combined pin missed ready fall");
	chk_restart_runs: assert property (
		conv_restart |-> ##[0:1] conv_run
	) else $error("restart without run");
	chk_write_restarts: assert property (
		$changed(cfg_word) && (cfg_word != 32'h0) |-> ##[0:1] conv_restart
	) else $error("register write without restart");
	chk_sleep_after_conv: assert property (
		$rose(sleep_mode) |-> $past(adc_valid, 1) || $past(adc_valid, 2) || !$past(conv_run)
	) else $error("sleep entered mid conversion");
	chk_sleep_stops_run: assert property (
		$rose(sleep_mode) |-> !conv_run
	) else $error("converter runs in sleep");
endmodule

// *** bench/asci_host.sv ***
// Host serial master model, clock mode 1
module asci_host (
	// Link outputs
	output logic            sclk,
	output logic            cs_n,
	output logic            din,
	// Link inputs
	input  wire logic       serial_out_ready_pin,
	input  wire logic       serial_out_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock parked low outside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// Select waits out the device's output enable lag
	task automatic sel(input logic on);
		if (on) begin
			cs_n = 1'b0;
			#100;
		end else begin
			#40;
			cs_n = 1'b1;
			din = ~din; // Released line shows no stale value
		end
	endtask

	// n bits MSB first: drive after rise, sample before fall
	task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			#32;
			sclk = 1'b1;
			din = tx[i];
			#32;
			// A released pin reads as the inverse of its last level
			rx[i] = serial_out_oe_n ? ~serial_out_ready_pin : serial_out_ready_pin;
			sclk = 1'b0;
		end
	endtask
endmodule

// *** bench/tb_adc_serial_command_interface.sv ***
// Self-checking bench for the serial command interface
module tb_adc_serial_command_interface;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TO_N  = 20;
	localparam int LIMIT = 20000;

	// Design signals
	logic        clk;
	logic        rst;
	logic        ce;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        serial_out_ready_pin;
	logic        serial_out_oe_n;
	logic        data_ready_n;
	logic [23:0] adc_raw;
	logic        adc_valid;
	logic        conv_run;
	logic        conv_restart;
	logic        sleep_mode;
	logic [31:0] cfg_word;
	// Bench state
	int          err_count;
	int          total_checks;
	int          cycles;
	int          restarts;
	logic [31:0] exp_cfg;
	logic [7:0]  rx;

	// Short timeout keeps the stall test brief
	asci_top #(.RAW_W(24), .TO_NORMAL(TO_N), .TO_TURBO(2 * TO_N)) dut (
		.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din),
		.serial_out_ready_pin(serial_out_ready_pin), .serial_out_oe_n(serial_out_oe_n),
		.data_ready_n(data_ready_n), .adc_raw(adc_raw), .adc_valid(adc_valid), .conv_run(conv_run),
		.conv_restart(conv_restart), .sleep_mode(sleep_mode), .cfg_word(cfg_word)
	);
	asci_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .serial_out_ready_pin(serial_out_ready_pin),
		.serial_out_oe_n(serial_out_oe_n));

	initial clk = 1'b0;
	always #10 clk = ~clk;

	// Restart counting and hang guard
	always @(posedge clk) begin
		cycles++;
		if (conv_restart === 1'b1) begin
			restarts++;
		end
		if (cycles == LIMIT) begin
			err_count++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Lands after the edge so flags are settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic send(input logic [7:0] b);
		host.bits(8, b, rx);
	endtask

	// Converter core delivers one result
	task automatic result(input logic [23:0] raw);
		@(posedge clk);
		adc_raw <= raw;
		adc_valid <= 1'b1;
		@(posedge clk);
		adc_valid <= 1'b0;
		tick(2);
	endtask

	// Two result bytes, data input held low
	task automatic read_res(input logic [15:0] exp);
		logic [7:0] hi;
		host.bits(8, 8'h00, hi);
		send(8'h00);
		chk(32'({hi, rx}), 32'(exp), "result bytes");
	endtask

	task automatic cmd(input logic [7:0] b);
		host.sel(1'b1);
		send(b);
		host.sel(1'b0);
		tick(6);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		host.sel(1'b1);
		send(8'h43);
		send(8'h11);
		send(8'h04);
		send(8'h5A);
		send(8'hA0);
		host.sel(1'b0);
		tick(6);
		exp_cfg = 32'hA05A0411;
		chk(cfg_word, exp_cfg, "cfg after write");
		chk(restarts, 1, "write restart");
		host.sel(1'b1);
		send(8'h2F);
		for (int i = 0; i < 4; i++) begin
			send(8'h00);
			chk(32'(rx), 32'(exp_cfg[8 * ((i + 3) % 4) +: 8]), "register read");
		end
		host.sel(1'b0);
	endtask

	task automatic t_unknown();
		host.sel(1'b1);
		send(8'hFF);
		send(8'h30);
		send(8'h0A);
		send(8'h00);
		host.sel(1'b0);
		tick(6);
		chk(cfg_word, exp_cfg, "cfg after unknown");
		chk(restarts + 32'(sleep_mode), 1, "state after unknown");
		// Cut frame: a stale bit count would misalign the start below
		host.sel(1'b1);
		host.bits(3, 8'h07, rx);
		host.sel(1'b0);
		tick(2);
		cmd(8'h08);
		chk(32'(conv_run), 1, "run after start");
		chk(restarts, 2, "restart after cut frame");
	endtask

	task automatic t_codes();
		logic [23:0] raw [4] = '{24'h7FFFFF, 24'h800000, 24'hFFFFFF, 24'h000000};
		logic [15:0] code [4] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			result(raw[i]);
			chk(32'(data_ready_n), 0, "ready on result");
			host.sel(1'b1);
			if (i == 1) begin
				send(8'h10);
			end
			read_res(code[i]);
			host.sel(1'b0);
			tick(6);
			chk(32'(data_ready_n), 1, "ready after read");
		end
	endtask

	task automatic t_gap();
		result(24'hFFFFFF);
		result(24'h001234);
		tick(3);
		chk(32'(data_ready_n), 1, "unread gap high");
		tick(40);
		chk(32'(data_ready_n), 0, "unread gap end");
		host.sel(1'b1);
		read_res(16'h1234);
		host.sel(1'b0);
	endtask

	task automatic t_select();
		host.sel(1'b1);
		send(8'h4C);
		send(8'h02);
		host.sel(1'b0);
		tick(6);
		exp_cfg[31:24] = 8'h02;
		chk(cfg_word, exp_cfg, "ready select write");
		// Frozen clock enable keeps the pin released despite select
		@(posedge clk);
		ce <= 1'b0;
		host.sel(1'b1);
		chk(32'(serial_out_oe_n), 1, "oe held by freeze");
		@(posedge clk);
		ce <= 1'b1;
		host.sel(1'b1);
		chk(32'(serial_out_oe_n), 0, "pin driven");
		result(24'hFFFFFF);
		chk(32'(serial_out_ready_pin), 0, "pin flags data");
		read_res(16'hFFFF);
		host.sel(1'b0);
		tick(6);
		chk(32'(serial_out_oe_n), 1, "pin released");
	endtask

	task automatic t_ignore_timeout();
		host.sel(1'b1);
		send(8'h10);
		send(8'h06);
		send(8'h00);
		host.sel(1'b0);
		tick(6);
		chk(cfg_word, exp_cfg, "command inside read");
		host.sel(1'b1);
		host.bits(4, 8'h0F, rx);
		tick(TO_N * 16 + 40);
		send(8'h21);
		send(8'h00);
		chk(32'(rx), 32'h11, "read after timeout");
		send(8'h00);
		chk(32'(rx), 32'h04, "read after timeout");
		host.sel(1'b0);
	endtask

	task automatic t_sleep_reset();
		cmd(8'h02);
		chk(32'(sleep_mode), 0, "sleep waits");
		result(24'h000000);
		chk(32'(sleep_mode), 1, "sleep entered");
		chk(cfg_word, exp_cfg, "cfg kept in sleep");
		cmd(8'h08);
		chk(32'({sleep_mode, conv_run}), 1, "wake on start");
		cmd(8'h06);
		chk(cfg_word, 0, "reset command");
		tick(2532);
		host.sel(1'b1);
		send(8'h23);
		for (int i = 0; i < 4; i++) begin
			send(8'h00);
			chk(32'(rx), 0, "register default");
		end
		host.sel(1'b0);
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		adc_raw = 24'h000000;
		adc_valid = 1'b0;
		err_count = 0;
		total_checks = 0;
		cycles = 0;
		restarts = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tick(4);
		chk(cfg_word, 0, "cfg reset value");
		t_regs();
		t_unknown();
		t_codes();
		t_gap();
		t_select();
		t_ignore_timeout();
		t_sleep_reset();
		end_sim();
	end
endmodule

bind asci_top asci_checker u_chk (
	.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
	.serial_out_ready_pin(serial_out_ready_pin), .serial_out_oe_n(serial_out_oe_n),
	.data_ready_n(data_ready_n), .adc_valid(adc_valid), .conv_run(conv_run),
	.conv_restart(conv_restart), .sleep_mode(sleep_mode), .cfg_word(cfg_word)
);

// *** verilog/asci_pkg.sv ***
// Constants and types of the ADC serial command interface
package asci_pkg;

	// Modulator clock division and timing, in modulator periods
	localparam int MOD_DIV_NORMAL = 16;
	localparam int MOD_DIV_TURBO  = 8;
	localparam int TO_NORMAL_MODS = 13955;
	localparam int TO_TURBO_MODS  = 27910;
	localparam int RDY_GAP_MODS   = 2;

	// Widths
	localparam int RES_W     = 16;
	localparam int RAW_W_DEF = 24;
	localparam int TO_W      = 15;

	// Saturation codes
	localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
	localparam logic [15:0] CODE_NEG_FS = 16'h8000;

	// Command opcodes (upper bits of the command byte)
	localparam logic [6:0] OP_RESET          = 7'h03;
	localparam logic [6:0] OP_START          = 7'h04;
	localparam logic [6:0] OP_SLEEP          = 7'h01;
	localparam logic [3:0] OP_RESULT_READ    = 4'h1;
	localparam logic [3:0] OP_REGISTER_READ  = 4'h2;
	localparam logic [3:0] OP_REGISTER_WRITE = 4'h4;

	// Configuration registers and the fields this block uses
	localparam int         CFG_REGS   = 4;
	localparam logic [7:0] CFG_RST    = 8'h00;
	localparam int         MODE_POS   = 11;
	localparam logic [1:0] MODE_TURBO = 2'h2;
	localparam int         CONV_POS   = 10;
	localparam int         RDYSEL_POS = 25;

	// Conversion control states
	typedef enum logic [2:0] {
		CS_IDLE  = 3'h1,
		CS_CONV  = 3'h2,
		CS_SLEEP = 3'h4
	} asci_conv_t;

endpackage

// *** verilog/asci_top.sv ***
// Serial command interface, result path and conversion control
module asci_sync #(
	parameter int W = 1
) (
	// Clocking
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// Two stages; only the second one is seen outside
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

module asci_top
	import asci_pkg::*;
#(
	parameter int RAW_W     = RAW_W_DEF,
	parameter int TO_NORMAL = TO_NORMAL_MODS,
	parameter int TO_TURBO  = TO_TURBO_MODS
) (
	// System clock
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Serial link
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             din,
	output logic                  serial_out_ready_pin,
	output logic                  serial_out_oe_n,
	output logic                  data_ready_n,
	// Converter core
	input  wire logic [RAW_W-1:0] adc_raw,
	input  wire logic             adc_valid,
	output logic                  conv_run,
	output logic                  conv_restart,
	output logic                  sleep_mode,
	output logic [31:0]           cfg_word
);

	if (RAW_W <= RES_W || TO_NORMAL < 1 || TO_TURBO < 1 || TO_TURBO >= 32768 || TO_NORMAL >= 32768) begin : g_chk
		$error("asci_top: unsupported parameter values");
	end

	localparam logic [3:0] DIVN_LAST = 4'(MOD_DIV_NORMAL - 1);
	localparam logic [3:0] DIVT_LAST = 4'(MOD_DIV_TURBO - 1);
	localparam logic [4:0] GAPN_LAST = 5'(RDY_GAP_MODS * MOD_DIV_NORMAL - 1);
	localparam logic [4:0] GAPT_LAST = 5'(RDY_GAP_MODS * MOD_DIV_TURBO - 1);
	localparam logic [TO_W-1:0] TON_LAST = TO_W'(TO_NORMAL - 1);
	localparam logic [TO_W-1:0] TOT_LAST = TO_W'(TO_TURBO - 1);
	localparam logic signed [RAW_W-1:0] RAW_MAX = {{(RAW_W - RES_W){1'b0}}, CODE_POS_FS};
	localparam logic signed [RAW_W-1:0] RAW_MIN = {{(RAW_W - RES_W){1'b1}}, CODE_NEG_FS};

	// Link side: receive path
	logic        link_rst;
	logic [2:0]  bit_q;
	logic [6:0]  sh_in_q;
	logic [2:0]  rd_cnt_q;
	logic        rd_reg_q;
	logic [2:0]  wr_cnt_q;
	logic [1:0]  addr_q;
	logic        ld_pend_q;
	logic        ld_res_q;
	logic [7:0]  ld_byte_q;
	logic        mid_q;
	logic [7:0]  cfg_q [CFG_REGS];
	logic [7:0]  stage_q [CFG_REGS];
	logic        start_tog_q;
	logic        sleep_tog_q;
	logic        reset_tog_q;
	logic        cfg_tog_q;
	// Link side: transmit path
	logic [15:0] sh_out_q;
	logic [3:0]  out_cnt_q;
	logic        out_bit_q;
	logic        out_act_q;
	logic        first_q;
	logic        ack_tog_q;
	logic        ack_seq_q;
	logic        tx_load_res;
	// Decode
	logic [7:0]  rx_byte;
	logic        rx_done;
	logic        rx_cmd;
	logic        rx_wdata;
	logic        rx_wlast;
	logic        op_rst;
	logic        op_start;
	logic        op_sleep;
	logic        op_res;
	logic        op_rrd;
	logic        op_wr;
	// System side
	logic [6:0]  x_s;
	logic [4:0]  x_p_q;
	logic        sel_s;
	logic        mid_s;
	logic        ev_start;
	logic        ev_sleep;
	logic        ev_reset;
	logic        ev_cfg;
	logic        ev_ack;
	logic [31:0] cfg_s_q;
	logic        oe_n_q;
	logic        turbo;
	logic        conv_mode_bit;
	logic        ready_on_output_select;
	logic [3:0]  div_q;
	logic        tick;
	logic [TO_W-1:0] to_cnt_q;
	logic        to_q;
	asci_conv_t  st_q;
	logic        pd_pend_q;
	logic        cont_q;
	logic        run_q;
	logic        restart_q;
	logic        sleep_q;
	logic [15:0] res_q;
	logic        res_seq_q;
	logic        data_ready_n_q;
	logic        pend_q;
	logic [15:0] pend_val_q;
	logic [4:0]  gap_q;
	logic [15:0] sat;

	////////////////////////////////////////////////////////////////////////
	// Link clock domain

	// Deselect, timeout or system reset clear the interface
	assign link_rst = rst | cs_n | to_q;

	// Byte assembly and command decode; unknown opcodes fall through
	always_comb begin
		rx_byte  = {sh_in_q, din};
		rx_done  = (bit_q == 3'h7);
		rx_cmd   = rx_done && rd_cnt_q == 3'h0 && wr_cnt_q == 3'h0;
		rx_wdata = rx_done && wr_cnt_q != 3'h0;
		rx_wlast = rx_wdata && wr_cnt_q == 3'h1;
		op_rst   = rx_cmd && rx_byte[7:1] == OP_RESET;
		op_start = rx_cmd && rx_byte[7:1] == OP_START;
		op_sleep = rx_cmd && rx_byte[7:1] == OP_SLEEP;
		op_res   = rx_cmd && rx_byte[7:4] == OP_RESULT_READ;
		op_rrd   = rx_cmd && rx_byte[7:4] == OP_REGISTER_READ;
		op_wr    = rx_cmd && rx_byte[7:4] == OP_REGISTER_WRITE;
	end

	// Receive sequencing on falling edges
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			bit_q     <= 3'h0;
			sh_in_q   <= 7'h00;
			rd_cnt_q  <= 3'h0;
			rd_reg_q  <= 1'b0;
			wr_cnt_q  <= 3'h0;
			addr_q    <= 2'h0;
			ld_pend_q <= 1'b0;
			ld_res_q  <= 1'b0;
			ld_byte_q <= 8'h00;
			mid_q     <= 1'b0;
		end else begin
			bit_q     <= bit_q + 3'h1;
			sh_in_q   <= rx_byte[6:0];
			ld_pend_q <= 1'b0;
			mid_q     <= 1'b1;
			if (op_res) begin
				rd_cnt_q  <= 3'h2;
				rd_reg_q  <= 1'b0;
				ld_pend_q <= 1'b1;
				ld_res_q  <= 1'b1;
			end else if (op_rrd) begin
				rd_cnt_q  <= {1'b0, rx_byte[1:0]} + 3'h1;
				rd_reg_q  <= 1'b1;
				addr_q    <= rx_byte[3:2] + 2'h1;
				ld_byte_q <= cfg_q[rx_byte[3:2]];
				ld_pend_q <= 1'b1;
				ld_res_q  <= 1'b0;
			end else if (op_wr) begin
				wr_cnt_q <= {1'b0, rx_byte[1:0]} + 3'h1;
				addr_q   <= rx_byte[3:2];
			end else if (rx_wdata) begin
				wr_cnt_q <= wr_cnt_q - 3'h1;
				addr_q   <= addr_q + 2'h1;
			end else if (rx_done && rd_cnt_q != 3'h0) begin
				rd_cnt_q <= rd_cnt_q - 3'h1;
				// Next register byte follows the previous one directly
				if (rd_reg_q && rd_cnt_q != 3'h1) begin
					ld_byte_q <= cfg_q[addr_q];
					addr_q    <= addr_q + 2'h1;
					ld_pend_q <= 1'b1;
					ld_res_q  <= 1'b0;
				end
			end
			// Idle again once a byte ends with nothing outstanding
			if (rx_done && !(op_res || op_rrd || op_wr) && (rx_wlast || wr_cnt_q == 3'h0)
				&& rd_cnt_q <= 3'h1) begin
				mid_q <= 1'b0;
			end
		end
	end

	// Registers and event toggles survive deselect; toggles must never reset spuriously
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CFG_REGS; i++) begin
				cfg_q[i]   <= CFG_RST;
				stage_q[i] <= CFG_RST;
			end
			start_tog_q <= 1'b0;
			sleep_tog_q <= 1'b0;
			reset_tog_q <= 1'b0;
			cfg_tog_q   <= 1'b0;
		end else if (op_rst) begin
			for (int i = 0; i < CFG_REGS; i++) begin
				cfg_q[i]   <= CFG_RST;
				stage_q[i] <= CFG_RST;
			end
			reset_tog_q <= ~reset_tog_q;
		end else begin
			if (op_start) begin
				start_tog_q <= ~start_tog_q;
			end
			if (op_sleep) begin
				sleep_tog_q <= ~sleep_tog_q;
			end
			if (op_wr) begin
				for (int i = 0; i < CFG_REGS; i++) begin
					stage_q[i] <= cfg_q[i];
				end
			end
			if (rx_wdata) begin
				stage_q[addr_q] <= rx_byte;
			end
			// All bytes land together on the last falling edge
			if (rx_wlast) begin
				for (int i = 0; i < CFG_REGS; i++) begin
					cfg_q[i] <= (i == addr_q) ? rx_byte : stage_q[i];
				end
				cfg_tog_q <= ~cfg_tog_q;
			end
		end
	end

	// First edge of a frame loads the result unless a command asks otherwise
	assign tx_load_res = ld_pend_q ? ld_res_q : first_q;

	// Transmit shifting on rising edges; res_q is quasi-static when sampled
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			sh_out_q  <= 16'h0000;
			out_cnt_q <= 4'h0;
			out_bit_q <= 1'b1;
			out_act_q <= 1'b0;
			first_q   <= 1'b1;
		end else begin
			first_q <= 1'b0;
			if (tx_load_res) begin
				out_bit_q <= res_q[15];
				sh_out_q  <= {res_q[14:0], 1'b0};
				out_cnt_q <= 4'hF;
				out_act_q <= 1'b1;
			end else if (ld_pend_q) begin
				out_bit_q <= ld_byte_q[7];
				sh_out_q  <= {ld_byte_q[6:0], 9'h000};
				out_cnt_q <= 4'h7;
				out_act_q <= 1'b1;
			end else if (out_cnt_q != 4'h0) begin
				out_bit_q <= sh_out_q[15];
				sh_out_q  <= {sh_out_q[14:0], 1'b0};
				out_cnt_q <= out_cnt_q - 4'h1;
			end else begin
				out_act_q <= 1'b0;
				out_bit_q <= 1'b1;
			end
		end
	end

	// Tell the system side which result went out
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			ack_tog_q <= 1'b0;
			ack_seq_q <= 1'b0;
		end else if (!link_rst && tx_load_res) begin
			ack_tog_q <= ~ack_tog_q;
			ack_seq_q <= res_seq_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossing into the system clock domain

	asci_sync #(
		.W(7)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.ce (ce),
		.d  ({~cs_n, mid_q, start_tog_q, sleep_tog_q, reset_tog_q, cfg_tog_q, ack_tog_q}),
		.q  (x_s)
	);

	assign {sel_s, mid_s} = x_s[6:5];
	assign {ev_start, ev_sleep, ev_reset, ev_cfg, ev_ack} = x_s[4:0] ^ x_p_q;

	// Edge history and register copy; cfg_q is stable long before its toggle arrives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			x_p_q   <= 5'h00;
			cfg_s_q <= {CFG_REGS{CFG_RST}};
			oe_n_q  <= 1'b1;
		end else if (ce) begin
			x_p_q  <= x_s[4:0];
			oe_n_q <= ~sel_s;
			if (ev_reset) begin
				cfg_s_q <= {CFG_REGS{CFG_RST}};
			end else if (ev_cfg) begin
				cfg_s_q <= {cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
			end
		end
	end

	assign turbo                  = (cfg_s_q[MODE_POS +: 2] == MODE_TURBO);
	assign conv_mode_bit          = cfg_s_q[CONV_POS];
	assign ready_on_output_select = cfg_s_q[RDYSEL_POS];

	////////////////////////////////////////////////////////////////////////
	// Modulator timing and interface timeout

	assign tick = (div_q == (turbo ? DIVT_LAST : DIVN_LAST));

	// Modulator period divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 4'h0;
		end else if (ce) begin
			div_q <= tick ? 4'h0 : div_q + 4'h1;
		end
	end

	// Counts modulator periods while a transfer is open; holds until link goes idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_cnt_q <= '0;
			to_q     <= 1'b0;
		end else if (ce) begin
			if (!mid_s) begin
				to_cnt_q <= '0;
				to_q     <= 1'b0;
			end else if (tick && !to_q) begin
				if (to_cnt_q == (turbo ? TOT_LAST : TON_LAST)) begin
					to_q <= 1'b1;
				end else begin
					to_cnt_q <= to_cnt_q + 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion control

	// Start and register write both restart the filter; write alone keeps continuous only if already converting continuously
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= CS_IDLE;
			pd_pend_q <= 1'b0;
			cont_q    <= 1'b0;
			run_q     <= 1'b0;
			restart_q <= 1'b0;
			sleep_q   <= 1'b0;
		end else if (ce) begin
			restart_q <= 1'b0;
			if (ev_reset) begin
				st_q      <= CS_IDLE;
				pd_pend_q <= 1'b0;
				cont_q    <= 1'b0;
				run_q     <= 1'b0;
				sleep_q   <= 1'b0;
			end else if (ev_start || ev_cfg) begin
				st_q      <= CS_CONV;
				cont_q    <= ev_start ? conv_mode_bit : (cont_q && st_q == CS_CONV);
				run_q     <= 1'b1;
				restart_q <= 1'b1;
				pd_pend_q <= 1'b0;
				sleep_q   <= 1'b0;
			end else begin
				case (st_q)
					CS_IDLE: begin
						if (ev_sleep) begin
							st_q    <= CS_SLEEP;
							sleep_q <= 1'b1;
						end
					end
					CS_CONV: begin
						if (ev_sleep) begin
							pd_pend_q <= 1'b1;
						end
						// Finish the running conversion before stopping
						if (adc_valid && (!cont_q || pd_pend_q || ev_sleep)) begin
							st_q      <= (pd_pend_q || ev_sleep) ? CS_SLEEP : CS_IDLE;
							sleep_q   <= pd_pend_q || ev_sleep;
							run_q     <= 1'b0;
							pd_pend_q <= 1'b0;
						end
					end
					CS_SLEEP: begin
						st_q <= CS_SLEEP;
					end
					default: begin
						st_q <= CS_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result buffer and data-ready

	// Clip the raw filter output to the sixteen-bit code range
	always_comb begin
		if ($signed(adc_raw) > RAW_MAX) begin
			sat = CODE_POS_FS;
		end else if ($signed(adc_raw) <= RAW_MIN) begin
			sat = CODE_NEG_FS;
		end else begin
			sat = adc_raw[15:0];
		end
	end

	// New data beats an acknowledge in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res_q          <= 16'h0000;
			res_seq_q      <= 1'b0;
			data_ready_n_q <= 1'b1;
			pend_q         <= 1'b0;
			pend_val_q     <= 16'h0000;
			gap_q          <= 5'h00;
		end else if (ce) begin
			if (ev_reset) begin
				res_q          <= 16'h0000;
				data_ready_n_q <= 1'b1;
				pend_q         <= 1'b0;
			end else if (adc_valid && st_q == CS_CONV) begin
				if (!data_ready_n_q && cont_q) begin
					pend_q         <= 1'b1;
					pend_val_q     <= sat;
					gap_q          <= 5'h00;
					data_ready_n_q <= 1'b1;
				end else begin
					res_q          <= sat;
					res_seq_q      <= ~res_seq_q;
					data_ready_n_q <= 1'b0;
					pend_q         <= 1'b0;
				end
			end else if (pend_q) begin
				if (gap_q == (turbo ? GAPT_LAST : GAPN_LAST)) begin
					res_q          <= pend_val_q;
					res_seq_q      <= ~res_seq_q;
					data_ready_n_q <= 1'b0;
					pend_q         <= 1'b0;
				end else begin
					gap_q <= gap_q + 5'h01;
				end
			end else if (ev_ack && ack_seq_q == res_seq_q) begin
				data_ready_n_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Idle combined pin mirrors ready when ready_on_output_select is set, else stays high; during a shift it carries data
	assign serial_out_ready_pin = out_act_q ? out_bit_q
		: (ready_on_output_select ? data_ready_n_q : 1'b1);
	assign serial_out_oe_n      = oe_n_q;
	assign data_ready_n         = data_ready_n_q;
	assign conv_run             = run_q;
	assign conv_restart         = restart_q;
	assign sleep_mode           = sleep_q;
	assign cfg_word             = cfg_s_q;

endmodule
